// ===== rtl/spfc_pkg.sv
package spfc_pkg;

	// ****************************************************************
	// Register map and field positions
	// ****************************************************************
	localparam logic [1:0] SPFC_ADDR_CTRL     = 2'h0;
	localparam logic [1:0] SPFC_ADDR_FUSE     = 2'h1;
	localparam logic [1:0] SPFC_ADDR_BOOTLOCK = 2'h2;
	localparam logic [1:0] SPFC_ADDR_PTR      = 2'h3;
	localparam logic [7:0] SPFC_CTRL_RESET    = 8'h00;
	localparam logic [7:0] SPFC_LOCK_RESET    = 8'hff;
	localparam int SPFC_BIT_IE   = 7;
	localparam int SPFC_BIT_BUSY = 6;
	localparam int SPFC_BIT_SIG  = 5;
	localparam int SPFC_BIT_RWWE = 4;
	localparam int SPFC_BIT_LOCK = 3;
	localparam int SPFC_BIT_PGWR = 2;
	localparam int SPFC_BIT_PGER = 1;
	localparam int SPFC_BIT_EN   = 0;

	// ****************************************************************
	// Command patterns in the low five bits
	// ****************************************************************
	localparam logic [4:0] SPFC_CMD_REEN = 5'h11;
	localparam logic [4:0] SPFC_CMD_LOCK = 5'h09;
	localparam logic [4:0] SPFC_CMD_PGWR = 5'h05;
	localparam logic [4:0] SPFC_CMD_PGER = 5'h03;
	localparam logic [4:0] SPFC_CMD_FILL = 5'h01;
	localparam logic [4:0] SPFC_CMD_SIG  = 5'h21;

	// ****************************************************************
	// Geometry, vectors and timing
	// ****************************************************************
	localparam int SPFC_WORD_BITS = 6;
	localparam int SPFC_PAGE_BITS = 7;
	localparam int SPFC_PAGE_WORDS = 64;
	localparam logic [15:0] SPFC_APP_VECTOR  = 16'h0000;
	localparam logic [15:0] SPFC_BOOT_VECTOR = 16'h1800;
	localparam logic [SPFC_PAGE_BITS-1:0] SPFC_HALTING_SECTION_FIRST_PAGE = 7'h60;
	localparam int SPFC_STORE_WINDOW = 4;
	localparam int SPFC_LOAD_WINDOW  = 3;
	localparam real SPFC_CLK_MHZ   = 250.0;
	localparam real SPFC_PROG_US   = 4000.0;
	localparam int  SPFC_PROG_CYC  = int'(SPFC_PROG_US * SPFC_CLK_MHZ);
	localparam int  SPFC_LOCK_CYC  = 16;

	typedef enum logic [2:0] {
		SPFC_OP_NONE,
		SPFC_OP_FILL,
		SPFC_OP_ERASE,
		SPFC_OP_WRITE,
		SPFC_OP_LOCK,
		SPFC_OP_REEN
	} spfc_op_t;

	typedef struct packed {
		logic        store;
		logic        load;
		logic [15:0] ptr;
		logic [15:0] data;
	} spfc_cpu_t;

	typedef struct packed {
		logic                      go;
		logic                      erase;
		logic [SPFC_PAGE_BITS-1:0] page;
	} spfc_flash_t;

endpackage : spfc_pkg

// ===== rtl/spfc_core.sv
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps

// ****************************************************************
// Self-programming flash sequencer
// ****************************************************************
// Function
// - Unprogrammed boot reset fuse starts at 0x0000, programmed starts at boot vector.
// - Fuses are inputs only; no CPU path alters them.
// - With hardware boot enabled, strap pin is sampled at reset release.
// - Strap low at release with hardware boot enabled selects boot vector.
// - Ready interrupt requested continuously while enabled and operation enable is clear.
// - Erase or write to READ_WHILE_WRITE_SECTION section sets busy flag and blocks its reads.
// - Busy flag clears on re-enable after programming, or when buffer load starts.
// - Re-enable command plus store within four cycles re-enables; ignored while busy.
// - Re-enable written during buffer load aborts it and discards buffered data.
// - Signature command: load within three cycles reads signature; store does nothing.
// - Lock command plus store programs boot lock bits from R0; bit auto-clears.
// - Load within three cycles after lock command returns lock or fuse by Z0.
// - Page write command plus store programs buffer into page; bit auto-clears.
// - Page erase command plus store erases page; bit auto-clears.
// - CPU is stalled during erase or write of a halting-section page.
// - Operation enable arms store for four cycles, then auto-clears.
// - Enable alone: store puts R1:R0 into buffer word by pointer, ignoring bit 0.
// - Operation enable stays set until erase or write finishes.
// - Only six command patterns start actions; other combinations start nothing, though bit 4 still clears the buffer.
// - Target address latched at start; pointer may change afterwards.
// - Low pointer bits pick word, high bits pick page; loads also use bit 0.
// - Temporary buffer clears after page write, re-enable and reset.
// - EEPROM write in progress blocks programming and fuse or lock reads.
module spfc_core #(
	parameter int PROG_CYC = spfc_pkg::SPFC_PROG_CYC
) (
	input  wire logic                  MCLK,
	input  wire logic                  ARST_N,
	input  wire logic [1:0]            REG_ADDR,
	input  wire logic [7:0]            REG_WDATA,
	input  wire logic                  REG_WR,
	input  wire logic                  REG_RD,
	output logic [7:0]                 REG_RDATA,
	input  wire spfc_pkg::spfc_cpu_t   CPU_REQ,
	input  wire logic                  GLOBAL_IE,
	input  wire logic                  EEPROM_BUSY,
	input  wire logic                  BOOT_RESET_FUSE,
	input  wire logic                  HARDWARE_BOOT_ENABLE_FUSE,
	input  wire logic                  BOOT_STRAP_PIN,
	input  wire logic [7:0]            FUSE_LOW,
	input  wire logic [7:0]            SIGNATURE_BYTE,
	output logic [15:0]                RESET_VECTOR,
	output logic                       RESET_VECTOR_VALID,
	output logic                       READY_IRQ,
	output logic                       CPU_STALL,
	output logic                       RWW_READ_BLOCK,
	output logic                       LOAD_VALID,
	output logic [7:0]                 LOAD_DATA,
	output spfc_pkg::spfc_flash_t      FLASH_CMD,
	output logic [15:0]                FLASH_WDATA,
	output logic [5:0]                 FLASH_WADDR
);
	import spfc_pkg::*;

	function automatic logic in_halting_section(input logic [SPFC_PAGE_BITS-1:0] page);
		in_halting_section = page >= SPFC_HALTING_SECTION_FIRST_PAGE;
	endfunction : in_halting_section

	logic [6:0]                ctrl_q;
	logic                      busy_q;
	logic [2:0]                win_q;
	logic                      run_q;
	logic [31:0]               cnt_q;
	logic                      halt_q;
	logic                      lock_op_q;
	logic                      page_op_q;
	logic [SPFC_PAGE_BITS-1:0] page_q;
	logic [7:0]                lock_q;
	logic [15:0]               ptr_sw_q;
	logic [15:0]               buf_q [SPFC_PAGE_WORDS];
	logic [SPFC_PAGE_WORDS-1:0] filled_q;
	logic                      boot_done_q;
	logic [4:0]                cmd;
	logic                      armed;
	logic                      wr_ctrl;
	logic                      store_ok;
	logic                      load_ok;
	logic                      buf_clear;
	logic [5:0]                widx;
	logic [SPFC_PAGE_BITS-1:0] zpage;

	assign cmd      = ctrl_q[4:0];
	assign armed    = ctrl_q[SPFC_BIT_EN] && !run_q;
	assign wr_ctrl  = REG_WR && REG_ADDR == SPFC_ADDR_CTRL;
	// Signature command shares the fill code in the low bits, so a store under it is dropped
	assign store_ok = armed && CPU_REQ.store && !EEPROM_BUSY && !wr_ctrl &&
		!ctrl_q[SPFC_BIT_SIG];
	assign load_ok  = armed && CPU_REQ.load && !EEPROM_BUSY && !wr_ctrl &&
		win_q < 3'(SPFC_LOAD_WINDOW);
	assign widx     = CPU_REQ.ptr[SPFC_WORD_BITS:1];
	assign zpage    = CPU_REQ.ptr[SPFC_WORD_BITS+SPFC_PAGE_BITS:SPFC_WORD_BITS+1];
	assign buf_clear = (store_ok && cmd == SPFC_CMD_PGWR) ||
		(store_ok && cmd == SPFC_CMD_REEN && !busy_q) ||
		(wr_ctrl && REG_WDATA[SPFC_BIT_RWWE]);

	// ****************************************************************
	// Boot vector selection
	// ****************************************************************
	// Fuses and strap are plain inputs, caught on the first clock after release
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			boot_done_q        <= 1'b0;
			RESET_VECTOR       <= SPFC_APP_VECTOR;
			RESET_VECTOR_VALID <= 1'b0;
		end else if (!boot_done_q) begin
			boot_done_q        <= 1'b1;
			RESET_VECTOR_VALID <= 1'b1;
			if (!BOOT_RESET_FUSE || (!HARDWARE_BOOT_ENABLE_FUSE && !BOOT_STRAP_PIN)) begin
				RESET_VECTOR <= SPFC_BOOT_VECTOR;
			end else begin
				RESET_VECTOR <= SPFC_APP_VECTOR;
			end
		end
	end

	// ****************************************************************
	// Control register and arming window
	// ****************************************************************
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_q <= SPFC_CTRL_RESET[6:0];
			win_q  <= 3'h0;
		end else if (wr_ctrl) begin
			ctrl_q[6] <= REG_WDATA[SPFC_BIT_IE];
			if (EEPROM_BUSY || run_q) begin
				ctrl_q[5:0] <= ctrl_q[5:0];
			end else if (REG_WDATA[5:0] == {1'b1, SPFC_CMD_FILL} ||
				(!REG_WDATA[5] && (REG_WDATA[4:0] == SPFC_CMD_REEN ||
				REG_WDATA[4:0] == SPFC_CMD_LOCK || REG_WDATA[4:0] == SPFC_CMD_PGWR ||
				REG_WDATA[4:0] == SPFC_CMD_PGER || REG_WDATA[4:0] == SPFC_CMD_FILL))) begin
				ctrl_q[5:0] <= REG_WDATA[5:0];
				win_q       <= 3'h0;
			end
		end else if (run_q) begin
			if (cnt_q == 32'h0) begin
				ctrl_q[5:0] <= 6'h00;
			end
		end else if (ctrl_q[SPFC_BIT_EN]) begin
			if (store_ok && (cmd == SPFC_CMD_PGER || cmd == SPFC_CMD_PGWR ||
				cmd == SPFC_CMD_LOCK)) begin
				ctrl_q[5:0] <= ctrl_q[5:0];
			end else if (store_ok || load_ok ||
				win_q == 3'(SPFC_STORE_WINDOW - 1)) begin
				ctrl_q[5:0] <= 6'h00;
			end else begin
				win_q <= win_q + 3'h1;
			end
		end
	end

	// ****************************************************************
	// Flash operation timer and address latch
	// ****************************************************************
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			run_q     <= 1'b0;
			cnt_q     <= 32'h0;
			halt_q    <= 1'b0;
			page_q    <= '0;
			lock_op_q <= 1'b0;
		end else if (run_q) begin
			if (cnt_q == 32'h0) begin
				run_q  <= 1'b0;
				halt_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - 32'h1;
			end
		end else if (store_ok && (cmd == SPFC_CMD_PGER || cmd == SPFC_CMD_PGWR)) begin
			run_q     <= 1'b1;
			lock_op_q <= 1'b0;
			cnt_q     <= 32'(PROG_CYC - 1);
			page_q    <= zpage;
			halt_q    <= in_halting_section(zpage);
		end else if (store_ok && cmd == SPFC_CMD_LOCK) begin
			run_q     <= 1'b1;
			lock_op_q <= 1'b1;
			cnt_q     <= 32'(SPFC_LOCK_CYC - 1);
		end
	end

	// ****************************************************************
	// Section busy, lock bits and pointer
	// ****************************************************************
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			busy_q <= 1'b0;
		end else if (store_ok && (cmd == SPFC_CMD_PGER || cmd == SPFC_CMD_PGWR) &&
			!in_halting_section(zpage)) begin
			busy_q <= 1'b1;
		end else if (store_ok && (cmd == SPFC_CMD_FILL || cmd == SPFC_CMD_REEN)) begin
			busy_q <= 1'b0;
		end
	end

	// Lock bits only move toward programmed; only reset restores them to unprogrammed
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			lock_q <= SPFC_LOCK_RESET;
		end else if (store_ok && cmd == SPFC_CMD_LOCK) begin
			lock_q <= lock_q & {2'h3, CPU_REQ.data[5:2], 2'h3};
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ptr_sw_q <= 16'h0000;
		end else if (CPU_REQ.store || CPU_REQ.load) begin
			ptr_sw_q <= CPU_REQ.ptr;
		end
	end

	// ****************************************************************
	// Temporary page buffer
	// ****************************************************************
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			filled_q <= '0;
		end else if (buf_clear) begin
			filled_q <= '0;
		end else if (store_ok && cmd == SPFC_CMD_FILL) begin
			filled_q[widx] <= 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (store_ok && cmd == SPFC_CMD_FILL) begin
			buf_q[widx] <= CPU_REQ.data;
		end
	end

	// ****************************************************************
	// Outputs to CPU and flash array
	// ****************************************************************
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			LOAD_VALID <= 1'b0;
			LOAD_DATA  <= 8'h00;
		end else begin
			LOAD_VALID <= load_ok && (cmd == SPFC_CMD_LOCK || ctrl_q[5]);
			if (load_ok && ctrl_q[5]) begin
				LOAD_DATA <= SIGNATURE_BYTE;
			end else if (load_ok && cmd == SPFC_CMD_LOCK) begin
				LOAD_DATA <= CPU_REQ.ptr[0] ? lock_q : FUSE_LOW;
			end
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			FLASH_CMD   <= '0;
			FLASH_WDATA <= 16'h0000;
			FLASH_WADDR <= 6'h00;
		end else begin
			FLASH_CMD.go    <= store_ok && (cmd == SPFC_CMD_PGER || cmd == SPFC_CMD_PGWR);
			FLASH_CMD.erase <= cmd == SPFC_CMD_PGER;
			FLASH_CMD.page  <= store_ok ? zpage : page_q;
			FLASH_WDATA     <= filled_q[widx] ? buf_q[widx] : 16'hffff;
			FLASH_WADDR     <= widx;
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			READY_IRQ      <= 1'b0;
			CPU_STALL      <= 1'b0;
			RWW_READ_BLOCK <= 1'b0;
			REG_RDATA      <= 8'h00;
		end else begin
			READY_IRQ      <= ctrl_q[6] && GLOBAL_IE && !ctrl_q[SPFC_BIT_EN];
			CPU_STALL      <= (run_q && halt_q && cnt_q != 32'h0) ||
				(store_ok && (cmd == SPFC_CMD_PGER || cmd == SPFC_CMD_PGWR) &&
				in_halting_section(zpage));
			RWW_READ_BLOCK <= busy_q;
			REG_RDATA      <= 8'h00;
			if (REG_RD) begin
				unique case (REG_ADDR)
					SPFC_ADDR_CTRL:     REG_RDATA <= {ctrl_q[6], busy_q, ctrl_q[5:0]};
					SPFC_ADDR_FUSE:     REG_RDATA <= {6'h00, HARDWARE_BOOT_ENABLE_FUSE,
						BOOT_RESET_FUSE};
					SPFC_ADDR_BOOTLOCK: REG_RDATA <= lock_q;
					SPFC_ADDR_PTR:      REG_RDATA <= ptr_sw_q[7:0];
				endcase
			end
		end
	end

endmodule : spfc_core

// ===== tb/spfc_chk.sv
`timescale 1ns/1ps
// ********
// Port checker
// ********
module spfc_chk import spfc_pkg::*; (
	input wire logic        MCLK,
	input wire logic        ARST_N,
	input wire spfc_cpu_t   CPU_REQ,
	input wire logic        EEPROM_BUSY,
	input wire logic        BOOT_RESET_FUSE,
	input wire logic        HARDWARE_BOOT_ENABLE_FUSE,
	input wire logic        BOOT_STRAP_PIN,
	input wire logic [15:0] RESET_VECTOR,
	input wire logic        RESET_VECTOR_VALID,
	input wire logic        CPU_STALL,
	input wire logic        RWW_READ_BLOCK,
	input wire logic        LOAD_VALID,
	input wire spfc_flash_t FLASH_CMD
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	chk_vector_pick: assert property ($rose(RESET_VECTOR_VALID) |-> RESET_VECTOR ==
		((!$past(BOOT_RESET_FUSE) || (!$past(HARDWARE_BOOT_ENABLE_FUSE) && !$past(BOOT_STRAP_PIN)))
		? SPFC_BOOT_VECTOR : SPFC_APP_VECTOR)) else $error("reset vector wrong");
	chk_go_once: assert property (FLASH_CMD.go |=> !FLASH_CMD.go)
		else $error("go longer than one cycle");
	chk_go_cause: assert property (FLASH_CMD.go |-> $past(CPU_REQ.store))
		else $error("go without store");
	chk_go_eeprom: assert property (FLASH_CMD.go |-> !$past(EEPROM_BUSY))
		else $error("go while eeprom busy");
	chk_load_once: assert property (LOAD_VALID |=> !LOAD_VALID)
		else $error("load valid too long");
	chk_load_cause: assert property (LOAD_VALID |-> $past(CPU_REQ.load))
		else $error("load valid without load");
	chk_block_rise: assert property ($rose(RWW_READ_BLOCK) |->
		$past(FLASH_CMD.go) || $past(FLASH_CMD.go, 2)) else $error("block without go");
	chk_stall_page: assert property (FLASH_CMD.go && FLASH_CMD.page >= SPFC_HALTING_SECTION_FIRST_PAGE
		|-> ##[0:1] CPU_STALL) else $error("no stall for halting page");
	cover property (FLASH_CMD.go && FLASH_CMD.erase);
	cover property (LOAD_VALID);
	cover property ($rose(CPU_STALL));
endmodule : spfc_chk
bind spfc_core spfc_chk spfc_chk_inst (.*);

// ===== tb/spfc_cpu_model.sv
`timescale 1ns/1ps
// ********
// CPU side: store and load pulses
// ********
module spfc_cpu_model import spfc_pkg::*; (
	input wire logic MCLK,
	output spfc_cpu_t CPU_REQ
);
	initial CPU_REQ = '0;
	// One instruction at a time; idle lines show the inverse so stale values never match
	task automatic op(input logic st, input logic [15:0] p, input logic [15:0] d);
		@(posedge MCLK);
		CPU_REQ <= '{store: st, load: !st, ptr: p, data: d};
		@(posedge MCLK);
		CPU_REQ <= '{store: 1'b0, load: 1'b0, ptr: ~p, data: ~d};
	endtask : op
endmodule : spfc_cpu_model

// ===== tb/spfc_core_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
	$display("BAD t=%0t got %h exp %h", $time, a, b); end end
module spfc_core_tb;
	import spfc_pkg::*;
	logic mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, gie = 0, eep = 0;
	logic brf = 1, hardware_boot_enable_fuse = 0, strap = 0, vld, irq, stall, blk, ld_v;
	logic [1:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata, ld_d;
	logic [15:0] vec, fwd;
	spfc_cpu_t cpu_req;
	spfc_flash_t fcmd;
	int err_total = 0, checks = 0;
	always #2 mclk = ~mclk;
	spfc_cpu_model cpu (.MCLK(mclk), .CPU_REQ(cpu_req));
	spfc_core #(.PROG_CYC(20)) spfc_core_inst (.MCLK(mclk), .ARST_N(arst_n),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .CPU_REQ(cpu_req), .GLOBAL_IE(gie), .EEPROM_BUSY(eep),
		.BOOT_RESET_FUSE(brf), .HARDWARE_BOOT_ENABLE_FUSE(hardware_boot_enable_fuse), .BOOT_STRAP_PIN(strap),
		.FUSE_LOW(8'h5a), .SIGNATURE_BYTE(8'h1e), .RESET_VECTOR(vec), .RESET_VECTOR_VALID(vld),
		.READY_IRQ(irq), .CPU_STALL(stall), .RWW_READ_BLOCK(blk), .LOAD_VALID(ld_v),
		.LOAD_DATA(ld_d), .FLASH_CMD(fcmd), .FLASH_WDATA(fwd), .FLASH_WADDR());
	// ********
	// Bus tasks
	// ********
	task automatic summarize;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic rdc(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] v;
		rd(a, v);
		`CHK(v & m, e)
	endtask : rdc
	task automatic wait_done;
		logic [7:0] v;
		for (int i = 0; i < 80; i++) begin
			rd(SPFC_ADDR_CTRL, v);
			if (v[0] === 1'b0)
				return;
		end
		err_total++;
		summarize();
	endtask : wait_done
	task automatic rst(input logic b, input logic h, input logic s, input logic [15:0] e);
		arst_n <= 1'b0;
		{brf, hardware_boot_enable_fuse, strap} <= {b, h, s};
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 `CHK(vec, e)
	endtask : rst
	task automatic ldc(input logic [7:0] c, input logic [15:0] p, input logic [7:0] e);
		wr(SPFC_ADDR_CTRL, c);
		cpu.op(1'b0, p, 16'h0000);
		#1 `CHK(ld_v, 1'b1)
		`CHK(ld_d, e)
	endtask : ldc
	// ********
	// Scenarios
	// ********
	initial begin
		rst(1'b1, 1'b0, 1'b1, SPFC_APP_VECTOR);
		rst(1'b0, 1'b1, 1'b1, SPFC_BOOT_VECTOR);
		rst(1'b1, 1'b1, 1'b0, SPFC_APP_VECTOR);
		rst(1'b1, 1'b0, 1'b0, SPFC_BOOT_VECTOR);
		rdc(SPFC_ADDR_CTRL, SPFC_CTRL_RESET, 8'hff);
		wr(SPFC_ADDR_FUSE, 8'h02);
		rdc(SPFC_ADDR_FUSE, 8'h01, 8'h03);
		wr(SPFC_ADDR_CTRL, 8'h01);
		cpu.op(1'b1, 16'h0007, 16'hbeef);
		rdc(SPFC_ADDR_CTRL, 8'h00, 8'hff);
		cpu.op(1'b0, 16'h0007, 16'h0000);
		#1 `CHK(fwd, 16'hbeef)
		rdc(SPFC_ADDR_PTR, 8'h07, 8'hff);
		wr(SPFC_ADDR_CTRL, 8'h21);
		cpu.op(1'b1, 16'h0007, 16'h1111);
		cpu.op(1'b0, 16'h0007, 16'h0000);
		#1 `CHK(fwd, 16'hbeef)
		wr(SPFC_ADDR_CTRL, 8'h10);
		cpu.op(1'b0, 16'h0007, 16'h0000);
		#1 `CHK(fwd, 16'hffff)
		wr(SPFC_ADDR_CTRL, 8'h05);
		cpu.op(1'b1, 16'h0280, 16'h1234);
		#1 `CHK(fcmd, spfc_flash_t'{1'b1, 1'b0, 7'h05})
		wr(SPFC_ADDR_CTRL, 8'h11);
		rdc(SPFC_ADDR_CTRL, 8'h45, 8'hff);
		`CHK(blk, 1'b1)
		wait_done;
		rdc(SPFC_ADDR_CTRL, 8'h40, 8'hff);
		wr(SPFC_ADDR_CTRL, 8'h11);
		cpu.op(1'b1, 16'h0000, 16'h0000);
		rdc(SPFC_ADDR_CTRL, 8'h00, 8'hff);
		wr(SPFC_ADDR_CTRL, 8'h03);
		cpu.op(1'b1, 16'h3080, 16'h5555);
		#1 `CHK(fcmd, spfc_flash_t'{1'b1, 1'b1, 7'h61})
		@(posedge mclk);
		#1 `CHK(stall, 1'b1)
		wait_done;
		`CHK(stall, 1'b0)
		wr(SPFC_ADDR_CTRL, 8'h03);
		repeat (4) @(posedge mclk);
		cpu.op(1'b1, 16'h0280, 16'h0000);
		#1 `CHK(fcmd.go, 1'b0)
		rdc(SPFC_ADDR_CTRL, 8'h00, 8'hff);
		wr(SPFC_ADDR_CTRL, 8'h87);
		rdc(SPFC_ADDR_CTRL, 8'h80, 8'hff);
		gie <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 `CHK(irq, 1'b1)
		wr(SPFC_ADDR_CTRL, 8'h81);
		repeat (2) @(posedge mclk);
		#1 `CHK(irq, 1'b0)
		gie <= 1'b0;
		ldc(8'h09, 16'h0001, SPFC_LOCK_RESET);
		ldc(8'h09, 16'h0000, 8'h5a);
		ldc(8'h21, 16'h0000, 8'h1e);
		wr(SPFC_ADDR_CTRL, 8'h09);
		cpu.op(1'b1, 16'h0001, 16'hffc3);
		wait_done;
		rdc(SPFC_ADDR_BOOTLOCK, 8'hc3, 8'hff);
		eep <= 1'b1;
		wr(SPFC_ADDR_CTRL, 8'h03);
		rdc(SPFC_ADDR_CTRL, 8'h00, 8'h7f);
		eep <= 1'b0;
		summarize();
	end
endmodule : spfc_core_tb
